// >>> rtl/oscdiv_irq.sv
// Purpose: Sticky event status, mask and level interrupt
// Assumes: Status is write-one-to-clear, a new event wins over the clear
// Notes: Mask has the status layout
`timescale 1ns/1ps
`default_nettype none
module oscdiv_irq
    import oscdiv_pkg::*;
#(
    parameter int W = IRQ_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] events,
    input wire logic wr_status,
    input wire logic wr_mask,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] status_q,
    output logic [W-1:0] mask_q,
    output logic irq
);
    logic [W-1:0] status_d;
    logic [W-1:0] mask_d;

    always_comb begin
        status_d = (status_q & ~(wr_status ? wdata : '0)) | events;
        mask_d = wr_mask ? wdata : mask_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
            mask_q <= '0;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
        end
    end

    assign irq = |(status_q & mask_q);
endmodule
`default_nettype wire

// >>> rtl/oscdiv_pkg.sv
// Purpose: Constants and types for the oscillator switch and clock divider
// Assumes: APB word registers, 32-bit data, 16-bit registers in low bits
// Notes: Offsets, keys and switch delay are plain defaults
package oscdiv_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
    localparam logic [7:0] OFS_CLK_DIV = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_UNLOCK = 8'h10;

    // Oscillator control field positions
    localparam int OSC_COSC_LSB = 12;
    localparam int OSC_NOSC_LSB = 8;
    localparam int OSC_UNUSED_BIT = 4;
    localparam int OSC_CF_BIT = 3;
    localparam int OSC_SWREQ_BIT = 0;

    // Clock divisor field positions
    localparam int DIV_ROI_BIT = 15;
    localparam int DIV_DOZE_LSB = 12;
    localparam int DIV_REDUCTION_MODE_EN_BIT = 11;
    localparam int DIV_FRCDIV_LSB = 8;
    localparam int DIV_PLLPOST_LSB = 6;
    localparam int DIV_PLLPRE_LSB = 0;

    // Codes and reset values
    localparam logic [2:0] OSC_CODE_BACKUP = 3'h4;
    localparam logic [2:0] OSC_CODE_RESET = 3'h0;
    localparam logic [2:0] DOZE_CODE_OFF = 3'h0;
    localparam logic [2:0] FRC_DIV_RESET = 3'h1;
    localparam logic [1:0] VCO_DIV_RESERVED = 2'h2;
    localparam logic [31:0] UNLOCK_KEY1 = 32'h0000_0046;
    localparam logic [31:0] UNLOCK_KEY2 = 32'h0000_0057;
    localparam logic [7:0] SWITCH_CYCLES = 8'h08;
    localparam int DOZE_TOP_SHIFT = 7;
    localparam int FRC_TOP_SHIFT = 8;

    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_CLK_FAIL = 0;
    localparam int IRQ_SWITCH_DONE = 1;
    localparam int IRQ_FRC_FAIL = 2;

    typedef struct packed {
        logic [2:0] current_osc_select;
        logic [2:0] new_osc_select;
        logic clock_fail_flag;
        logic osc_switch_request;
    } oscdiv_osc_t;

    typedef struct packed {
        logic recover_on_irq;
        logic [2:0] doze;
        logic reduction_mode_en;
        logic [2:0] fast_rc_postscale;
        logic [1:0] vco_output_divider;
        logic [4:0] pll_input_prescale;
    } oscdiv_div_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_WAIT = 2'b01,
        SW_DONE = 2'b11
    } oscdiv_sw_state_t;

endpackage

// >>> rtl/oscdiv_ratio_div.sv
// Purpose: Power-of-two tick generator for clock ratios
// Assumes: Code n gives one tick every 2^n cycles, top code uses TOP_SHIFT
// Notes: Counter restarts when it reaches or passes the limit
`timescale 1ns/1ps
`default_nettype none
module oscdiv_ratio_div
    import oscdiv_pkg::*;
#(
    parameter int TOP_SHIFT = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] ratio_code,
    output logic tick
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [8:0] limit;

    always_comb begin
        if (ratio_code == 3'h7) begin
            limit = 9'(9'h001 << TOP_SHIFT) - 9'h001;
        end else begin
            limit = (9'h001 << ratio_code) - 9'h001;
        end
        tick = ({1'b0, cnt_q} >= limit);
        cnt_d = tick ? 8'h00 : cnt_q + 8'h01;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/oscdiv_top.sv
// Purpose: Oscillator switch control and clock divisor registers on APB
// Assumes: presetn is the power-on reset, fail inputs come from other domains
// Notes: pready is always high, unmapped offsets answer pslverr
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module oscdiv_top
    import oscdiv_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clock_fail_monitor,
    input wire logic fast_rc_fail,
    input wire logic irq_event,
    output logic [2:0] osc_select,
    output logic [2:0] fast_rc_postscale,
    output logic [1:0] vco_output_divider,
    output logic [4:0] pll_input_prescale,
    output logic instruction_clock_tick,
    output logic fast_rc_tick,
    output logic irq
);
    //////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic wr_en;
    logic rd_setup;
    logic hit;
    logic wr_osc;
    logic wr_div;
    logic wr_unlock;

    always_comb begin
        hit = (paddr == OFS_OSC_CTRL) || (paddr == OFS_CLK_DIV) ||
              (paddr == OFS_IRQ_STATUS) || (paddr == OFS_IRQ_MASK) ||
              (paddr == OFS_UNLOCK);
        wr_en = psel && penable && pwrite && hit;
        rd_setup = psel && !penable && !pwrite;
        wr_osc = wr_en && (paddr == OFS_OSC_CTRL);
        wr_div = wr_en && (paddr == OFS_CLK_DIV);
        wr_unlock = wr_en && (paddr == OFS_UNLOCK);
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] cfm_sync_q;
    logic [1:0] frf_sync_q;
    logic cfm_prev_q;
    logic frf_prev_q;
    logic cfm_rise;
    logic frf_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfm_sync_q <= 2'h0;
            frf_sync_q <= 2'h0;
            cfm_prev_q <= 1'b0;
            frf_prev_q <= 1'b0;
        end else begin
            cfm_sync_q <= {cfm_sync_q[0], clock_fail_monitor};
            frf_sync_q <= {frf_sync_q[0], fast_rc_fail};
            cfm_prev_q <= cfm_sync_q[1];
            frf_prev_q <= frf_sync_q[1];
        end
    end

    assign cfm_rise = cfm_sync_q[1] && !cfm_prev_q;
    assign frf_rise = frf_sync_q[1] && !frf_prev_q;

    //////////////////////////////////////////////////////////////////////////
    // Unlock sequence: key 1 then key 2 arms one oscillator control write
    logic key1_seen_q;
    logic key1_seen_d;
    logic armed_q;
    logic armed_d;

    always_comb begin
        key1_seen_d = key1_seen_q;
        armed_d = armed_q;
        if (wr_unlock) begin
            key1_seen_d = (pwdata == UNLOCK_KEY1);
            armed_d = key1_seen_q && (pwdata == UNLOCK_KEY2);
        end else if (wr_en) begin
            key1_seen_d = 1'b0;
            if (wr_osc) begin
                armed_d = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key1_seen_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            key1_seen_q <= key1_seen_d;
            armed_q <= armed_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Oscillator control and switch sequencer
    oscdiv_osc_t osc_q;
    oscdiv_osc_t osc_d;
    oscdiv_sw_state_t sw_q;
    oscdiv_sw_state_t sw_d;
    logic [7:0] sw_cnt_q;
    logic [7:0] sw_cnt_d;
    logic switch_done;
    logic [2:0] wr_nosc;

    always_comb begin
        osc_d = osc_q;
        sw_d = sw_q;
        sw_cnt_d = sw_cnt_q;
        switch_done = 1'b0;
        wr_nosc = pwdata[OSC_NOSC_LSB +: 3];
        if (wr_osc && armed_q) begin
            if (wr_nosc != OSC_CODE_BACKUP) begin
                osc_d.new_osc_select = wr_nosc;
            end
            if (!pwdata[OSC_CF_BIT]) begin
                osc_d.clock_fail_flag = 1'b0;
            end
        end
        case (sw_q)
            SW_IDLE: begin
                if (wr_osc && armed_q && pwdata[OSC_SWREQ_BIT]) begin
                    osc_d.osc_switch_request = 1'b1;
                    sw_cnt_d = SWITCH_CYCLES - 8'h01;
                    sw_d = SW_WAIT;
                end
            end
            SW_WAIT: begin
                if (sw_cnt_q == 8'h00) begin
                    sw_d = SW_DONE;
                end else begin
                    sw_cnt_d = sw_cnt_q - 8'h01;
                end
            end
            SW_DONE: begin
                osc_d.current_osc_select = osc_q.new_osc_select;
                osc_d.osc_switch_request = 1'b0;
                switch_done = 1'b1;
                sw_d = SW_IDLE;
            end
            default: begin
                sw_d = SW_IDLE;
            end
        endcase
        if (frf_rise) begin
            osc_d.current_osc_select = OSC_CODE_BACKUP;
        end
        if (cfm_rise) begin
            osc_d.clock_fail_flag = 1'b1;
        end
    end

    // Power-on reset only; no other reset reaches these registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_q <= '{OSC_CODE_RESET, OSC_CODE_RESET, 1'b0, 1'b0};
            sw_q <= SW_IDLE;
            sw_cnt_q <= 8'h00;
        end else begin
            osc_q <= osc_d;
            sw_q <= sw_d;
            sw_cnt_q <= sw_cnt_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Clock divisor register
    oscdiv_div_t div_q;
    oscdiv_div_t div_d;
    logic [2:0] doze_next;

    always_comb begin
        div_d = div_q;
        doze_next = div_q.doze;
        if (wr_div) begin
            if (!div_q.reduction_mode_en) begin
                doze_next = pwdata[DIV_DOZE_LSB +: 3];
            end
            div_d.doze = doze_next;
            div_d.recover_on_irq = pwdata[DIV_ROI_BIT];
            div_d.reduction_mode_en = pwdata[DIV_REDUCTION_MODE_EN_BIT] &&
                                      (doze_next != DOZE_CODE_OFF);
            div_d.fast_rc_postscale = pwdata[DIV_FRCDIV_LSB +: 3];
            if (pwdata[DIV_PLLPOST_LSB +: 2] != VCO_DIV_RESERVED) begin
                div_d.vco_output_divider = pwdata[DIV_PLLPOST_LSB +: 2];
            end
            div_d.pll_input_prescale = pwdata[DIV_PLLPRE_LSB +: 5];
        end
        if (div_q.recover_on_irq && irq_event) begin
            div_d.reduction_mode_en = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '{1'b0, DOZE_CODE_OFF, 1'b0, FRC_DIV_RESET, 2'h0, 5'h00};
        end else begin
            div_q <= div_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Ratio dividers
    logic [2:0] cpu_code;

    assign cpu_code = div_q.reduction_mode_en ? div_q.doze : DOZE_CODE_OFF;

    oscdiv_ratio_div #(.TOP_SHIFT(DOZE_TOP_SHIFT)) u_cpu_div (
        .pclk(pclk),
        .presetn(presetn),
        .ratio_code(cpu_code),
        .tick(instruction_clock_tick)
    );

    oscdiv_ratio_div #(.TOP_SHIFT(FRC_TOP_SHIFT)) u_frc_div (
        .pclk(pclk),
        .presetn(presetn),
        .ratio_code(div_q.fast_rc_postscale),
        .tick(fast_rc_tick)
    );

    //////////////////////////////////////////////////////////////////////////
    // Interrupts
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    oscdiv_irq #(.W(IRQ_W)) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .events({frf_rise, switch_done, cfm_rise}),
        .wr_status(wr_en && (paddr == OFS_IRQ_STATUS)),
        .wr_mask(wr_en && (paddr == OFS_IRQ_MASK)),
        .wdata(pwdata[IRQ_W-1:0]),
        .status_q(irq_status),
        .mask_q(irq_mask),
        .irq(irq)
    );

    //////////////////////////////////////////////////////////////////////////
    // Read data, captured in the setup phase
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (rd_setup) begin
            rdata_d = 32'h0000_0000;
            case (paddr)
                OFS_OSC_CTRL: begin
                    rdata_d[OSC_COSC_LSB +: 3] = osc_q.current_osc_select;
                    rdata_d[OSC_NOSC_LSB +: 3] = osc_q.new_osc_select;
                    rdata_d[OSC_CF_BIT] = osc_q.clock_fail_flag;
                    rdata_d[OSC_SWREQ_BIT] = osc_q.osc_switch_request;
                end
                OFS_CLK_DIV: begin
                    rdata_d[DIV_ROI_BIT] = div_q.recover_on_irq;
                    rdata_d[DIV_DOZE_LSB +: 3] = div_q.doze;
                    rdata_d[DIV_REDUCTION_MODE_EN_BIT] = div_q.reduction_mode_en;
                    rdata_d[DIV_FRCDIV_LSB +: 3] = div_q.fast_rc_postscale;
                    rdata_d[DIV_PLLPOST_LSB +: 2] = div_q.vco_output_divider;
                    rdata_d[DIV_PLLPRE_LSB +: 5] = div_q.pll_input_prescale;
                end
                OFS_IRQ_STATUS: begin
                    rdata_d[IRQ_W-1:0] = irq_status;
                end
                OFS_IRQ_MASK: begin
                    rdata_d[IRQ_W-1:0] = irq_mask;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rdata_q;
    assign osc_select = osc_q.current_osc_select;
    assign fast_rc_postscale = div_q.fast_rc_postscale;
    assign vco_output_divider = div_q.vco_output_divider;
    assign pll_input_prescale = div_q.pll_input_prescale;

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cf_sets_flag: assert property (cfm_rise |=> osc_q.clock_fail_flag)
        else $error("clock fail flag not set after monitor failure");
    a_switch_starts: assert property (
        (sw_q == SW_IDLE && wr_osc && armed_q && pwdata[OSC_SWREQ_BIT])
        |=> osc_q.osc_switch_request && sw_q == SW_WAIT)
        else $error("switch request did not start a switch");
    a_switch_ends: assert property (
        $rose(osc_q.osc_switch_request) |-> osc_q.osc_switch_request [*8] ##1
        osc_q.osc_switch_request ##1 !osc_q.osc_switch_request)
        else $error("switch request did not clear after the switch time");
    a_locked_write: assert property ((wr_osc && !armed_q) |=> $stable(osc_q.new_osc_select))
        else $error("oscillator control changed without unlock");
    a_backup_refused: assert property (
        (wr_osc && pwdata[OSC_NOSC_LSB +: 3] == OSC_CODE_BACKUP)
        |=> osc_q.new_osc_select != OSC_CODE_BACKUP)
        else $error("backup code entered the new selection field");
    a_frc_backup: assert property (frf_rise |=> osc_select == OSC_CODE_BACKUP)
        else $error("current selection not forced to backup");
    a_bit4_zero: assert property ((rd_setup && paddr == OFS_OSC_CTRL) |=> !prdata[OSC_UNUSED_BIT])
        else $error("unused oscillator bit read as one");
    a_roi_clears: assert property ((div_q.recover_on_irq && irq_event) |=> !div_q.reduction_mode_en)
        else $error("recover on interrupt left doze enabled");
    a_doze_locked: assert property ((wr_div && div_q.reduction_mode_en) |=> $stable(div_q.doze))
        else $error("doze field changed while doze enabled");
    a_reduction_mode_en_refused: assert property ((div_q.doze == DOZE_CODE_OFF) |-> !div_q.reduction_mode_en)
        else $error("doze enabled with zero reduction field");
    a_ratio_one: assert property (!div_q.reduction_mode_en |-> instruction_clock_tick)
        else $error("processor ratio not one with doze off");
endmodule
`default_nettype wire

// >>> testbench/oscdiv_test.sv
// Purpose: Self-checking bench for the oscillator switch and clock divider
// Assumes: APB slave with zero wait states, unlock keys and offsets from the package
// Notes: The bench drives every port itself; there is no partner model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module oscdiv_test;
    import oscdiv_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, last_err;
    logic clock_fail_monitor, fast_rc_fail, irq_event;
    logic instruction_clock_tick, fast_rc_tick;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] osc_select, fast_rc_postscale;
    logic [1:0] vco_output_divider;
    logic [4:0] pll_input_prescale;
    int error_cnt, compares, cpu_ticks, frc_ticks;

    oscdiv_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clock_fail_monitor(clock_fail_monitor),
        .fast_rc_fail(fast_rc_fail), .irq_event(irq_event), .osc_select(osc_select),
        .fast_rc_postscale(fast_rc_postscale), .vco_output_divider(vco_output_divider),
        .pll_input_prescale(pll_input_prescale),
        .instruction_clock_tick(instruction_clock_tick),
        .fast_rc_tick(fast_rc_tick), .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    //////////////////////////////////////////////////////////////////////////
    // Closing report and bus tasks
    task automatic wrap_up();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb_xfer(1'b1, a, d, q);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb_xfer(1'b0, a, 32'h0000_0000, q);
        `CHK(q, e)
    endtask

    task automatic unlock();
        wr_reg(OFS_UNLOCK, UNLOCK_KEY1);
        wr_reg(OFS_UNLOCK, UNLOCK_KEY2);
    endtask

    task automatic count_ticks(input int n);
        cpu_ticks = 0;
        frc_ticks = 0;
        repeat (n) begin
            @(negedge pclk);
            if (instruction_clock_tick === 1'b1) cpu_ticks++;
            if (fast_rc_tick === 1'b1) frc_ticks++;
        end
    endtask

    //////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        error_cnt = 0;
        compares = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, clock_fail_monitor, fast_rc_fail, irq_event} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;

        // Reset values and postscaler default
        chk_rd(OFS_OSC_CTRL, 32'h0000_0000);
        chk_rd(OFS_CLK_DIV, 32'h0000_0100);
        chk_rd(OFS_IRQ_STATUS, 32'h0000_0000);
        chk_rd(OFS_IRQ_MASK, 32'h0000_0000);
        `CHK(fast_rc_postscale, FRC_DIV_RESET)
        count_ticks(64);
        `CHK(frc_ticks, 32)
        `CHK(cpu_ticks, 64)
        $display("test reset done");

        // Locked write, then unlocked switch with unused bits set
        wr_reg(OFS_OSC_CTRL, 32'h0000_0317);
        chk_rd(OFS_OSC_CTRL, 32'h0000_0000);
        unlock();
        // Starts from plain fast RC, never PLL to PLL
        wr_reg(OFS_OSC_CTRL, 32'h0000_0317);
        chk_rd(OFS_OSC_CTRL, 32'h0000_0301);
        for (int i = 0; i < 20; i++) begin
            apb_xfer(1'b0, OFS_OSC_CTRL, 32'h0000_0000, rd);
            if (rd[0] === 1'b0) break;
        end
        `CHK(rd, 32'h0000_3300)
        `CHK(osc_select, 3'h3)
        chk_rd(OFS_OSC_CTRL, 32'h0000_3300);
        unlock();
        wr_reg(OFS_OSC_CTRL, 32'h0000_0400);
        chk_rd(OFS_OSC_CTRL, 32'h0000_3300);
        $display("test switch done");

        // Fail events, interrupt mask and clear
        wr_reg(OFS_IRQ_MASK, 32'h0000_0001);
        `CHK(irq, 1'b0)
        clock_fail_monitor <= 1'b1;
        repeat (6) @(posedge pclk);
        chk_rd(OFS_OSC_CTRL, 32'h0000_3308);
        chk_rd(OFS_IRQ_STATUS, 32'h0000_0003);
        `CHK(irq, 1'b1)
        fast_rc_fail <= 1'b1;
        repeat (6) @(posedge pclk);
        `CHK(osc_select, OSC_CODE_BACKUP)
        chk_rd(OFS_OSC_CTRL, 32'h0000_4308);
        clock_fail_monitor <= 1'b0;
        fast_rc_fail <= 1'b0;
        wr_reg(OFS_IRQ_STATUS, 32'h0000_0007);
        chk_rd(OFS_IRQ_STATUS, 32'h0000_0000);
        `CHK(irq, 1'b0)
        unlock();
        wr_reg(OFS_OSC_CTRL, 32'h0000_0300);
        chk_rd(OFS_OSC_CTRL, 32'h0000_4300);
        $display("test fail events done");

        // Divisor register: doze locks, reserved divider, recover on interrupt
        wr_reg(OFS_CLK_DIV, 32'h0000_0900);
        chk_rd(OFS_CLK_DIV, 32'h0000_0100);
        wr_reg(OFS_CLK_DIV, 32'h0000_2900);
        chk_rd(OFS_CLK_DIV, 32'h0000_2900);
        wr_reg(OFS_CLK_DIV, 32'h0000_5900);
        chk_rd(OFS_CLK_DIV, 32'h0000_2900);
        count_ticks(64);
        `CHK(cpu_ticks, 16)
        wr_reg(OFS_CLK_DIV, 32'h0000_2980);
        chk_rd(OFS_CLK_DIV, 32'h0000_2900);
        wr_reg(OFS_CLK_DIV, 32'h0000_29df);
        chk_rd(OFS_CLK_DIV, 32'h0000_29df);
        `CHK(vco_output_divider, 2'h3)
        `CHK(pll_input_prescale, 5'h1f)
        wr_reg(OFS_CLK_DIV, 32'h0000_a9df);
        @(posedge pclk);
        irq_event <= 1'b1;
        @(posedge pclk);
        irq_event <= 1'b0;
        chk_rd(OFS_CLK_DIV, 32'h0000_a1df);
        count_ticks(64);
        `CHK(cpu_ticks, 64)
        $display("test divisor done");

        // Unmapped address answers an error and reads zero
        wr_reg(8'h20, 32'hffff_ffff);
        `CHK(last_err, 1'b1)
        apb_xfer(1'b0, 8'h20, 32'h0000_0000, rd);
        `CHK(rd, 32'h0000_0000)
        `CHK(last_err, 1'b1)
        $display("test unmapped done");
        wrap_up();
    end
endmodule
`default_nettype wire
